// file: shared/compact_timer_pkg.sv
/*
  package for the compact timer: register offsets, field positions,
  reset values, mode and clock-select encodings, carrier structs.
  assumes a 32-bit ahb-lite bus, one register per aligned word.
*/
package compact_timer_pkg;

  // register byte addresses
  localparam logic [7:0] off_control_0    = 8'h00;
  localparam logic [7:0] off_control_1    = 8'h04;
  localparam logic [7:0] off_count_low    = 8'h08;
  localparam logic [7:0] off_count_high   = 8'h0C;
  localparam logic [7:0] off_compare_low  = 8'h10;
  localparam logic [7:0] off_compare_high = 8'h14;
  localparam logic [7:0] off_period       = 8'h18;
  localparam logic [7:0] off_flags        = 8'h1C;

  // field positions
  localparam int pos_pause    = 7;
  localparam int pos_run      = 3;
  localparam int pos_clear    = 0;
  localparam int pos_polarity = 2;
  localparam int pos_ocontrol = 3;
  localparam int pos_flag_a   = 0;
  localparam int pos_flag_p   = 1;

  // reset values
  localparam logic [7:0]  rst_byte  = 8'h00;
  localparam logic [15:0] rst_word  = 16'h0000;
  localparam logic [7:0]  ctl0_mask = 8'hF8;

  // divider counts
  localparam logic [1:0] div_sys4  = 2'h3;
  localparam logic [5:0] div_high  = 6'h3F;
  localparam logic [3:0] div_high16 = 4'hF;
  localparam logic [7:0] sub_div_default = 8'hFF;

  typedef enum logic [1:0] {
    mode_compare = 2'b00,
    mode_undef   = 2'b01,
    mode_pwm     = 2'b10,
    mode_timer   = 2'b11
  } mode_field_t;

  typedef enum logic [2:0] {
    clk_sys4   = 3'b000,
    clk_sys    = 3'b001,
    clk_high16 = 3'b010,
    clk_high64 = 3'b011,
    clk_sub0   = 3'b100,
    clk_sub1   = 3'b101,
    clk_ext_r  = 3'b110,
    clk_ext_f  = 3'b111
  } clock_select_t;

  typedef struct packed {
    mode_field_t mode_field;
    logic [1:0]  output_function;
    logic        output_control;
    logic        output_polarity;
    logic        duty_period_swap;
    logic        clear_select;
  } control_1_t;

  typedef struct packed {
    logic          pause_bit;
    clock_select_t clock_select;
    logic          run_enable;
    logic [2:0]    unused;
  } control_0_t;

endpackage : compact_timer_pkg

// file: verification/ext_clock_source.sv
/*
  far-side model: drives the timer's external clock pin.
  assumes the bench calls pulses() just after an hclk rising edge.
*/
`timescale 1ns/1ps
module ext_clock_source (
  input  wire logic hclk,
  output logic      pin
);
  // pin stands low between bursts
  initial pin = 1'b0;

  // n full pulses, each level held hw hclk cycles
  task automatic pulses(input int n, input int hw);
    repeat (n) begin
      repeat (hw) @(posedge hclk);
      pin <= 1'b1;
      repeat (hw) @(posedge hclk);
      pin <= 1'b0;
    end
    repeat (6) @(posedge hclk);
  endtask
endmodule // ext_clock_source

// file: verification/tb_top.sv
/*
  self-checking bench for the compact timer over ahb-lite.
  assumes zero-wait slave; ext pin from ext_clock_source.
*/
`timescale 1ns/1ps
module tb_top;
  import compact_timer_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, ext_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, fn;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, tpin, fa, fp, oc, pol;
  logic [7:0]  hi;
  int          err_total, compares, seed, cnt, n, ex;

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  assign hready = hreadyout;

  compact_timer u_compact_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_clock_pin(ext_pin),
    .timer_output_pin(tpin), .compare_a_flag(fa), .compare_p_flag(fp)
  );
  ext_clock_source u_ext_clock_source (.hclk(hclk), .pin(ext_pin));

  task check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(a, 1'b0, 8'h00);
    check(nm, rd, {24'h00_0000, e});
  endtask

  function automatic logic cmp_pin(input logic [1:0] f, input logic c, p);
    logic l;
    case (f)
      2'b00: l = c;
      2'b01: l = 1'b0;
      2'b10: l = 1'b1;
      default: l = ~c;
    endcase
    return l ^ p;
  endfunction

  function automatic int div_of(input int s);
    case (s)
      0: return 4;
      1: return 1;
      2: return 16;
      3: return 64;
      default: return 256;
    endcase
  endfunction

  task give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    err_total++;
    give_verdict;
  end

  initial begin
    seed = 32'h9929_b3c9;
    err_total = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, plus one unmapped word
    for (int i = 0; i < 9; i++) rdc(8'(i * 4), 8'h00, "reset");
    check("pin flags", 32'({tpin, fa, fp}), 32'h0000_0000);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00, "unmapped");
    check("okay resp", 32'({hreadyout, hresp}), 32'h2);
    wr(off_control_0, 8'hFF);
    rdc(off_control_0, 8'hF8, "ctl0 low bits");
    wr(off_control_0, 8'h00);
    // shared low-byte buffer
    wr(off_compare_low, 8'hAB);
    rdc(off_compare_low, 8'hAB, "buffer read");
    rdc(off_compare_high, 8'h00, "cmp high");
    rdc(off_compare_low, 8'h00, "cmp low kept");
    wr(off_compare_low, 8'hAB);
    wr(off_compare_high, 8'h12);
    wr(off_compare_low, 8'h55);
    rdc(off_compare_high, 8'h12, "cmp high");
    rdc(off_compare_low, 8'hAB, "cmp low");
    wr(off_compare_low, 8'h00);
    wr(off_compare_high, 8'h00);
    // internal clock rates
    for (int s = 0; s < 6; s++) begin
      wr(off_control_0, 8'h00);
      wr(off_control_0, {1'b0, 3'(s), 4'h8});
      repeat (1024) @(posedge hclk);
      wr(off_control_0, 8'h00);
      xfer(off_count_high, 1'b0, 8'h00);
      hi = rd[7:0];
      xfer(off_count_low, 1'b0, 8'h00);
      cnt = int'({hi, rd[7:0]});
      ex = 1024 / div_of(s);
      check("rate", 32'(cnt >= ex - 1 && cnt <= ex + 4), 32'h1);
    end
    // pin edges with pause
    for (int e = 0; e < 2; e++) begin
      n = ($random(seed) & 7) + 1;
      wr(off_control_0, 8'h00);
      wr(off_control_0, {3'b011, 1'(e), 4'h8});
      u_ext_clock_source.pulses(n, 2 + e);
      wr(off_control_0, {3'b111, 1'(e), 4'h8});
      u_ext_clock_source.pulses(3, 2);
      wr(off_control_0, {3'b011, 1'(e), 4'h8});
      u_ext_clock_source.pulses(2, 3);
      rdc(off_count_high, 8'h00, "ext count hi");
      rdc(off_count_low, 8'(n + 2), "ext count");
    end
    // compare match output
    for (int f = 0; f < 4; f++) begin
      fn = 2'(f);
      oc = 1'($random(seed));
      pol = 1'($random(seed));
      n = ($random(seed) & 15) + 1;
      wr(off_control_0, 8'h00);
      wr(off_control_1, {2'b00, fn, oc, pol, 2'b00});
      wr(off_compare_low, 8'(n));
      wr(off_compare_high, 8'h00);
      wr(off_flags, 8'h03);
      wr(off_control_0, 8'h68);
      repeat (3) @(posedge hclk);
      check("init pin", 32'(tpin), 32'(oc ^ pol));
      u_ext_clock_source.pulses(n + 3, 2);
      check("match pin", 32'(tpin), 32'(cmp_pin(fn, oc, pol)));
      check("flag a", 32'({fa, fp}), 32'h2);
      wr(off_flags, 8'h01);
      repeat (2) @(posedge hclk);
      check("flag a clr", 32'(fa), 32'h0);
      wr(off_control_0, 8'h00);
      wr(off_control_0, 8'h68);
      repeat (3) @(posedge hclk);
      check("restart pin", 32'(tpin), 32'(oc ^ pol));
      rdc(off_count_high, 8'h00, "restart hi");
      rdc(off_count_low, 8'h00, "restart lo");
    end
    // period match clears, then compare-a clears
    wr(off_control_0, 8'h00);
    wr(off_control_1, 8'h00);
    wr(off_period, 8'h01);
    wr(off_flags, 8'h03);
    wr(off_control_0, 8'h18);
    repeat (600) @(posedge hclk);
    check("flag p", 32'(fp), 32'h1);
    rdc(off_count_high, 8'h00, "p clear");
    // clear edge then 599 ticks with a 256-clock period
    rdc(off_count_low, 8'((600 - 1) % 256), "p period");
    wr(off_control_0, 8'h00);
    wr(off_control_1, 8'h01);
    wr(off_compare_low, 8'h00);
    wr(off_compare_high, 8'h02);
    wr(off_flags, 8'h03);
    wr(off_control_0, 8'h18);
    repeat (1100) @(posedge hclk);
    check("a clear flags", 32'({fa, fp}), 32'h2);
    xfer(off_count_high, 1'b0, 8'h00);
    check("a clear", 32'(rd <= 32'h0000_0002), 32'h1);
    // forced pwm levels, then undefined and timer modes
    for (int m = 0; m < 4; m++) begin
      oc = 1'($random(seed));
      pol = 1'($random(seed));
      wr(off_control_0, 8'h00);
      wr(off_control_1, m < 2 ? {2'b10, 2'(m), oc, pol, 2'b00}
                             : {1'(m - 2), 1'b1, 6'h3C});
      wr(off_control_0, 8'h08);
      repeat (3) @(posedge hclk);
      ex = m < 2 ? int'((oc ^ (m == 0)) ^ pol) : 0;
      check("mode pin", 32'(tpin), 32'(ex));
    end
    give_verdict;
  end
endmodule // tb_top

// file: verilog/compact_timer.sv
/*
  compact timer: 16-bit up-counter, comparators a and p, output pin,
  byte registers behind an ahb-lite slave with a shared low-byte buffer.
  assumes external_clock_pin is asynchronous; high and sub clocks are
  derived from hclk by dividers.
*/
`timescale 1ns/1ps
module compact_timer
  import compact_timer_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin,
  output logic             compare_a_flag,
  output logic             compare_p_flag
);

  control_0_t  ctl0_reg;
  control_1_t  ctl1_reg;
  logic [15:0] count_reg;
  logic [15:0] cmp_a_reg;
  logic [7:0]  period_reg;
  logic [7:0]  buffer_reg;
  logic        level_reg;
  logic        run_prev_reg;
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic        ext_s3_reg;
  logic [1:0]  div4_reg;
  logic [5:0]  divh_reg;
  logic [7:0]  divs_reg;
  logic        ph_valid_reg;
  logic        ph_write_reg;
  logic [7:0]  ph_addr_reg;
  logic        tick;
  logic        match_a;
  logic        match_p;
  logic        run_rise;
  logic        drive_level;
  logic        rd_strobe;
  logic [7:0]  rd_addr;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= rst_byte;
    end else if (hready) begin
      ph_valid_reg <= hsel & htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg  <= haddr[7:0];
    end
  end

  // reads take effect in the address phase so data is registered
  assign rd_strobe = hsel & htrans[1] & ~hwrite & hready;
  assign rd_addr   = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_strobe) begin
      case (rd_addr)
        off_control_0:    hrdata <= {24'h00_0000, ctl0_reg & ctl0_mask};
        off_control_1:    hrdata <= {24'h00_0000, ctl1_reg};
        off_count_low:    hrdata <= {24'h00_0000, buffer_reg};
        off_compare_low:  hrdata <= {24'h00_0000, buffer_reg};
        off_count_high:   hrdata <= {24'h00_0000, count_reg[15:8]};
        off_compare_high: hrdata <= {24'h00_0000, cmp_a_reg[15:8]};
        off_period:       hrdata <= {24'h00_0000, period_reg};
        off_flags:        hrdata <= {30'h0000_0000, compare_p_flag,
                                     compare_a_flag};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // shared low-byte buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_reg <= rst_byte;
    end else if (rd_strobe && rd_addr == off_count_high) begin
      buffer_reg <= count_reg[7:0];
    end else if (rd_strobe && rd_addr == off_compare_high) begin
      buffer_reg <= cmp_a_reg[7:0];
    end else if (ph_valid_reg && ph_write_reg &&
                 ph_addr_reg == off_compare_low) begin
      buffer_reg <= hwdata[7:0];
    end
  end

  // control and compare registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_reg   <= control_0_t'(rst_byte);
      ctl1_reg   <= control_1_t'(rst_byte);
      cmp_a_reg  <= rst_word;
      period_reg <= rst_byte;
    end else if (ph_valid_reg && ph_write_reg) begin
      case (ph_addr_reg)
        off_control_0:    ctl0_reg <= control_0_t'(hwdata[7:0] & ctl0_mask);
        off_control_1:    ctl1_reg <= control_1_t'(hwdata[7:0]);
        off_compare_high: cmp_a_reg <= {hwdata[7:0], buffer_reg};
        off_period:       period_reg <= hwdata[7:0];
        default:          ;
      endcase
    end
  end

  // clock dividers for system/4, high, sub
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div4_reg <= 2'h0;
      divh_reg <= 6'h00;
      divs_reg <= rst_byte;
    end else begin
      div4_reg <= div4_reg + 2'h1;
      divh_reg <= divh_reg + 6'h01;
      divs_reg <= (divs_reg == sub_div_default) ? rst_byte
                                                : divs_reg + 8'h01;
    end
  end

  // external pin synchroniser and edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  always_comb begin
    case (ctl0_reg.clock_select)
      clk_sys4:   tick = (div4_reg == div_sys4);
      clk_sys:    tick = 1'b1;
      clk_high16: tick = (divh_reg[3:0] == div_high16);
      clk_high64: tick = (divh_reg == div_high);
      clk_sub0:   tick = (divs_reg == sub_div_default);
      clk_sub1:   tick = (divs_reg == sub_div_default);
      clk_ext_r:  tick = ext_s2_reg & ~ext_s3_reg;
      clk_ext_f:  tick = ~ext_s2_reg & ext_s3_reg;
      default:    tick = 1'b0;
    endcase
  end

  // comparators
  assign match_a  = (count_reg == cmp_a_reg);
  // p fires on the tick that would carry the count to period*256
  assign match_p  = (count_reg[7:0] == 8'hFF) &&
                    (8'(count_reg[15:8] + 8'h01) == period_reg);
  assign run_rise = ctl0_reg.run_enable & ~run_prev_reg;
  wire   counting = ctl0_reg.run_enable & ~ctl0_reg.pause_bit & tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= ctl0_reg.run_enable;
    end
  end

  // counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= rst_word;
    end else if (run_rise) begin
      count_reg <= rst_word;
    end else if (counting) begin
      if (ctl1_reg.mode_field != mode_pwm && ctl1_reg.clear_select &&
          match_a) begin
        count_reg <= rst_word;
      end else if ((ctl1_reg.mode_field == mode_pwm ||
                    !ctl1_reg.clear_select) && match_p &&
                   count_reg != rst_word) begin
        count_reg <= rst_word;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // flags, set wins over clear
  wire flag_wr = ph_valid_reg && ph_write_reg && ph_addr_reg == off_flags;
  wire set_a   = counting && match_a && cmp_a_reg != rst_word;
  wire set_p   = counting && match_p && count_reg != rst_word &&
                 (!ctl1_reg.clear_select ||
                  ctl1_reg.mode_field == mode_pwm);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      if (set_a) compare_a_flag <= 1'b1;
      else if (flag_wr && hwdata[pos_flag_a]) compare_a_flag <= 1'b0;
      if (set_p) compare_p_flag <= 1'b1;
      else if (flag_wr && hwdata[pos_flag_p]) compare_p_flag <= 1'b0;
    end
  end

  // output level state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg <= 1'b0;
    end else if (run_rise) begin
      level_reg <= ctl1_reg.output_control;
    end else if (ctl1_reg.mode_field == mode_compare && set_a) begin
      case (ctl1_reg.output_function)
        2'b01:   level_reg <= 1'b0;
        2'b10:   level_reg <= 1'b1;
        2'b11:   level_reg <= ~level_reg;
        default: level_reg <= level_reg;
      endcase
    end
  end

  // pwm: with function 2'b10 active from count 0 until a-match, period set by p; other functions force a fixed level
  always_comb begin
    case (ctl1_reg.output_function)
      2'b00:   drive_level = ~ctl1_reg.output_control;
      2'b01:   drive_level = ctl1_reg.output_control;
      2'b10:   drive_level = (count_reg < cmp_a_reg) ?
                 ctl1_reg.output_control : ~ctl1_reg.output_control;
      default: drive_level = ~ctl1_reg.output_control;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 1'b0;
    end else begin
      case (ctl1_reg.mode_field)
        mode_compare: timer_output_pin <= level_reg ^
                        ctl1_reg.output_polarity;
        mode_pwm:     timer_output_pin <= drive_level ^
                        ctl1_reg.output_polarity;
        default:      timer_output_pin <= 1'b0;
      endcase
    end
  end

  property p_run_clear;
    @(posedge hclk) disable iff (!hresetn)
      run_rise |=> count_reg == 16'h0000;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("count not cleared on run rising edge");

  property p_pause_hold;
    @(posedge hclk) disable iff (!hresetn)
      ctl0_reg.pause_bit && !run_rise |=> $stable(count_reg);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("count moved while paused");

  property p_off_hold;
    @(posedge hclk) disable iff (!hresetn)
      !ctl0_reg.run_enable |=> $stable(count_reg);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved while off");

  property p_flag_a_sticky;
    @(posedge hclk) disable iff (!hresetn)
      compare_a_flag && !flag_wr |=> compare_a_flag;
  endproperty
  a_flag_a_sticky: assert property (p_flag_a_sticky)
    else $error("compare a flag dropped");

  property p_flag_p_set;
    @(posedge hclk) disable iff (!hresetn)
      set_p |=> compare_p_flag;
  endproperty
  a_flag_p_set: assert property (p_flag_p_set)
    else $error("compare p flag not set");

  property p_ctl0_low_zero;
    @(posedge hclk) disable iff (!hresetn)
      rd_strobe && rd_addr == off_control_0 |=> hrdata[2:0] == 3'b000;
  endproperty
  a_ctl0_low_zero: assert property (p_ctl0_low_zero)
    else $error("control 0 low bits not zero");

  sequence s_high_read;
    rd_strobe && rd_addr == off_count_high;
  endsequence
  property p_buffer_capture;
    @(posedge hclk) disable iff (!hresetn)
      s_high_read |=> buffer_reg == $past(count_reg[7:0]);
  endproperty
  a_buffer_capture: assert property (p_buffer_capture)
    else $error("low byte not latched on high read");

  property p_high_write;
    @(posedge hclk) disable iff (!hresetn)
      ph_valid_reg && ph_write_reg && ph_addr_reg == off_compare_high
        |=> cmp_a_reg == {$past(hwdata[7:0]), $past(buffer_reg)};
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("compare a pair not loaded");

  property p_run_level;
    @(posedge hclk) disable iff (!hresetn)
      run_rise |=> level_reg == $past(ctl1_reg.output_control);
  endproperty
  a_run_level: assert property (p_run_level)
    else $error("initial level not applied");

  property p_flag_p_sticky;
    @(posedge hclk) disable iff (!hresetn)
      compare_p_flag && !flag_wr |=> compare_p_flag;
  endproperty
  a_flag_p_sticky: assert property (p_flag_p_sticky)
    else $error("compare p flag dropped");

  property p_low_write;
    @(posedge hclk) disable iff (!hresetn)
      ph_valid_reg && ph_write_reg && ph_addr_reg == off_compare_low
        |=> $stable(cmp_a_reg);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("compare a changed on low byte write");

  sequence s_plain_tick;
    counting && !run_rise && !match_a && !match_p;
  endsequence
  property p_count_step;
    @(posedge hclk) disable iff (!hresetn)
      s_plain_tick |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not advance on a tick");

endmodule // compact_timer
